/* hw/scir_regs.sv */
`timescale 1ns/1ps
module scir_regs
  import scir_pkg::*;
#(
  parameter logic [7:0] PAGE = SCIR_PAGE0 // Register page of this instance
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic [7:0] page_sel, // Current register page pointer
  input wire logic [7:0] addr, // Register address in page
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata, // Read data, registered
  input wire scir_evt_t evt, // Hardware event pulses
  input wire logic rx_word_valid, // Received word strobe
  input wire logic [7:0] rx_word, // Received word
  input wire logic rx_ninth, // Ninth bit of received word
  input wire logic rx_after_break, // Word follows a break
  output scir_dma_t dma_ptr, // Pointer fields for DMA controller
  output logic rx_dma_req, // Receive DMA request
  output logic tx_dma_req, // Transmit DMA request
  output logic [7:0] tx_data, // Transmit buffer content
  output logic tx_load, // Transmit buffer written, one cycle
  output logic irq_req, // Interrupt request level
  output logic [7:0] irq_vec // Vector presented to the handler
);
  logic [7:0] rdcp_q, rdap_q, tdcp_q, tdap_q, vbase_q, acmp_q, imsk_q, ista_q;
  logic [7:0] rxb_q, txb_q, idp_q, chr_q, clk_q, brh_q, brl_q, sic_q, soc_q;
  logic [7:0] rdata_d;
  logic tx_load_q, match, addr_mode, take_word, pass_q;
  logic sel, wsel, rsel;
  logic err_irq, brk_irq, rxd_irq, txe_irq;
  scir_ev_t ev_d;

  function automatic logic wr_at(input logic [7:0] a);
    return wsel && addr == a;
  endfunction

  assign sel = page_sel == PAGE;
  assign wsel = sel && wr_en && clk_en;
  assign rsel = sel && rd_en && clk_en;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdcp_q <= SCIR_RST8;
      rdap_q <= SCIR_RST8;
      tdcp_q <= SCIR_RST8;
      tdap_q <= SCIR_RST8;
      vbase_q <= SCIR_RST8;
      acmp_q <= SCIR_RST8;
      chr_q <= SCIR_RST8;
      clk_q <= SCIR_RST8;
      brh_q <= SCIR_RST8;
      brl_q <= SCIR_RST8;
      sic_q <= SCIR_RST8;
      soc_q <= SCIR_RST8;
    end else begin
      if (wr_at(SCIR_A_RDCP)) rdcp_q <= wdata;
      if (wr_at(SCIR_A_RDAP)) rdap_q <= wdata;
      if (wr_at(SCIR_A_TDCP)) tdcp_q <= wdata;
      if (wr_at(SCIR_A_TDAP)) tdap_q <= wdata;
      if (wr_at(SCIR_A_IVEC)) vbase_q <= {wdata[7:3], 3'h0};
      if (wr_at(SCIR_A_ACMP)) acmp_q <= wdata;
      if (wr_at(SCIR_A_CHR)) chr_q <= wdata;
      if (wr_at(SCIR_A_CLK)) clk_q <= wdata;
      if (wr_at(SCIR_A_BRH)) brh_q <= wdata;
      if (wr_at(SCIR_A_BRL)) brl_q <= wdata;
      if (wr_at(SCIR_A_SIC)) sic_q <= wdata;
      if (wr_at(SCIR_A_SOC)) soc_q <= wdata;
    end
  end

  assign dma_ptr = '{rx_cnt_addr: rdcp_q[7:1], rx_space_select: rdcp_q[0],
                     rx_ptr_addr: rdap_q[7:1], rx_extension_select: rdap_q[0],
                     tx_cnt_addr: tdcp_q[7:1], tx_space_select: tdcp_q[0],
                     tx_ptr_addr: tdap_q[7:1], tx_extension_select: tdap_q[0]};

  // DMA enables clear in hardware when the counter runs out
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idp_q <= SCIR_RST8;
    end else if (clk_en) begin
      if (wr_at(SCIR_A_IDP)) idp_q <= wdata;
      if (evt.rx_dma_zero) idp_q[SCIR_P_RXD] <= 1'b0;
      if (evt.tx_dma_zero) idp_q[SCIR_P_TXD] <= 1'b0;
    end
  end

  // Address compare: AMEN,AM = 00 ninth bit, 01 search, 10 match+ninth, 11 after break
  assign addr_mode = !(idp_q[SCIR_P_AMEN] == 1'b0 && chr_q[SCIR_C_AM] == 1'b1);
  always_comb begin
    case ({idp_q[SCIR_P_AMEN], chr_q[SCIR_C_AM]})
      2'b00: match = rx_ninth;
      2'b01: match = rx_word == acmp_q;
      2'b10: match = rx_ninth && rx_word == acmp_q;
      2'b11: match = rx_after_break && rx_word == acmp_q;
      default: match = 1'b0;
    endcase
  end

  // Once matched, data flows to the buffer until an unmatched address arrives
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pass_q <= 1'b0;
    end else if (clk_en && rx_word_valid && addr_mode) begin
      if (match) pass_q <= 1'b1;
      else if (rx_ninth || rx_after_break) pass_q <= 1'b0;
    end
  end

  assign take_word = rx_word_valid && !match &&
                     (!addr_mode || pass_q || idp_q[SCIR_P_AMEN] == 1'b0 &&
                      chr_q[SCIR_C_AM] == 1'b0 && !rx_ninth);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxb_q <= SCIR_RST8;
    end else if (clk_en && take_word) begin
      rxb_q <= rx_word;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ista_q <= SCIR_RST8;
    end else if (clk_en) begin
      ista_q <= (wr_at(SCIR_A_ISTA) ? (ista_q & wdata) : ista_q) |
                {evt.overrun, evt.framing, evt.parity,
                 rx_word_valid && match, evt.brk, take_word,
                 evt.tx_buf_empty, evt.tx_shift_empty};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      imsk_q <= SCIR_IMSK_RST;
    end else if (clk_en) begin
      imsk_q <= (wr_at(SCIR_A_IMSK) ?
                 ((wdata & SCIR_IMSK_SWMASK) | (imsk_q & wdata & ~SCIR_IMSK_SWMASK)) :
                 imsk_q);
      if (evt.rx_dma_zero) imsk_q[SCIR_M_RX_BLOCK_END_FLAG] <= 1'b1;
      if (evt.tx_dma_zero) imsk_q[SCIR_M_TX_BLOCK_END_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txb_q <= SCIR_RST8;
      tx_load_q <= 1'b0;
    end else if (clk_en) begin
      tx_load_q <= wr_at(SCIR_A_BUF);
      if (wr_at(SCIR_A_BUF)) txb_q <= wdata;
    end
  end
  assign tx_data = txb_q;
  assign tx_load = tx_load_q;

  // DMA requests bypass the data masks
  assign rx_dma_req = idp_q[SCIR_P_RXD] && ista_q[SCIR_S_DP];
  assign tx_dma_req = idp_q[SCIR_P_TXD] &&
                      (imsk_q[SCIR_M_BSN] ? ista_q[SCIR_S_BEM] : ista_q[SCIR_S_SEM]);

  assign err_irq = imsk_q[SCIR_M_RXE] &&
                   (ista_q[SCIR_S_OE] || ista_q[SCIR_S_FE] || ista_q[SCIR_S_PE]);
  assign brk_irq = imsk_q[SCIR_M_RXA] && ista_q[SCIR_S_AP] ||
                   imsk_q[SCIR_M_RXB] && ista_q[SCIR_S_BP];
  assign rxd_irq = imsk_q[SCIR_M_RX_DATA_IRQ_MASK] && (imsk_q[SCIR_M_RX_BLOCK_END_FLAG] ||
                   !idp_q[SCIR_P_RXD] && ista_q[SCIR_S_DP]);
  assign txe_irq = imsk_q[SCIR_M_TX_DATA_IRQ_MASK] && (imsk_q[SCIR_M_TX_BLOCK_END_FLAG] ||
                   !idp_q[SCIR_P_TXD] &&
                   (imsk_q[SCIR_M_BSN] ? ista_q[SCIR_S_BEM] : ista_q[SCIR_S_SEM]));

  // Fixed internal priority: error, break/address, receive, transmit
  always_comb begin
    if (err_irq) ev_d = SCIR_EV_ERR;
    else if (brk_irq) ev_d = SCIR_EV_BRK;
    else if (rxd_irq) ev_d = SCIR_EV_RXD;
    else ev_d = SCIR_EV_TXE;
  end

  assign irq_req = err_irq || brk_irq || rxd_irq || txe_irq;
  assign irq_vec = {vbase_q[7:3], ev_d, 1'b0};

  always_comb begin
    case (addr)
      SCIR_A_RDCP: rdata_d = rdcp_q;
      SCIR_A_RDAP: rdata_d = rdap_q;
      SCIR_A_TDCP: rdata_d = tdcp_q;
      SCIR_A_TDAP: rdata_d = tdap_q;
      SCIR_A_IVEC: rdata_d = irq_vec;
      SCIR_A_ACMP: rdata_d = acmp_q;
      SCIR_A_IMSK: rdata_d = imsk_q;
      SCIR_A_ISTA: rdata_d = ista_q;
      SCIR_A_BUF: rdata_d = rxb_q;
      SCIR_A_IDP: rdata_d = idp_q;
      SCIR_A_CHR: rdata_d = chr_q;
      SCIR_A_CLK: rdata_d = clk_q;
      SCIR_A_BRH: rdata_d = brh_q;
      SCIR_A_BRL: rdata_d = brl_q;
      SCIR_A_SIC: rdata_d = sic_q;
      SCIR_A_SOC: rdata_d = soc_q;
      default: rdata_d = SCIR_RST8;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= SCIR_RST8;
    end else if (rsel) begin
      rdata <= rdata_d;
    end
  end

  a_vec_low_zero: assert property (@(posedge clk_sys) disable iff (reset)
    rsel && addr == SCIR_A_IVEC |=> rdata[0] == 1'b0)
    else $error("vector bit zero not zero");
  a_eob_rx_set: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && evt.rx_dma_zero |=> imsk_q[SCIR_M_RX_BLOCK_END_FLAG] && !idp_q[SCIR_P_RXD])
    else $error("receive end of block not flagged");
  a_eob_tx_set: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && evt.tx_dma_zero |=> imsk_q[SCIR_M_TX_BLOCK_END_FLAG] && !idp_q[SCIR_P_TXD])
    else $error("transmit end of block not flagged");
  a_status_no_set: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_at(SCIR_A_ISTA) && !ista_q[SCIR_S_OE] && !evt.overrun
    |=> !ista_q[SCIR_S_OE])
    else $error("software set a status flag");
  a_err_mask: assert property (@(posedge clk_sys) disable iff (reset)
    !imsk_q[SCIR_M_RXE] |-> !err_irq)
    else $error("masked error interrupt raised");
  a_brk_mask: assert property (@(posedge clk_sys) disable iff (reset)
    imsk_q[SCIR_M_RXB] && ista_q[SCIR_S_BP] |-> irq_req)
    else $error("break interrupt missing");
  a_addr_match: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && rx_word_valid && match |=> ista_q[SCIR_S_AP])
    else $error("address pending not set");
  a_tx_buf_load: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_BUF) |=> txb_q == $past(wdata) && tx_load)
    else $error("transmit buffer not loaded");
  a_err_vector: assert property (@(posedge clk_sys) disable iff (reset)
    err_irq |-> irq_vec[2:1] == SCIR_EV_ERR)
    else $error("wrong source code");

  // Register access and pointer fields
  a_page_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    !sel |-> !wsel && !rsel)
    else $error("access taken on another page");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !rsel |=> rdata == $past(rdata))
    else $error("read data changed without a read");

  a_buf_read: assert property (@(posedge clk_sys) disable iff (reset)
    rsel && addr == SCIR_A_BUF |=> rdata == $past(rxb_q))
    else $error("buffer read did not return receive data");

  a_buf_split: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_BUF) && !take_word |=> rxb_q == $past(rxb_q))
    else $error("transmit write reached receive buffer");

  a_rx_cnt: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_RDCP) |=> dma_ptr.rx_cnt_addr == $past(wdata[7:1]))
    else $error("receive counter pointer wrong");

  a_rx_space: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_RDCP) |=> dma_ptr.rx_space_select == $past(wdata[0]))
    else $error("receive space select wrong");

  a_rx_ptr: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_RDAP) |=> {dma_ptr.rx_ptr_addr, dma_ptr.rx_extension_select} == $past(wdata))
    else $error("receive address pointer wrong");

  a_tx_cnt: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_TDCP) |=> {dma_ptr.tx_cnt_addr, dma_ptr.tx_space_select} == $past(wdata))
    else $error("transmit counter pointer wrong");

  a_tx_ptr: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_TDAP) |=> {dma_ptr.tx_ptr_addr, dma_ptr.tx_extension_select} == $past(wdata))
    else $error("transmit address pointer wrong");

  // Vector encoding follows the fixed source priority
  a_vec_base: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_IVEC) |=> irq_vec[7:3] == $past(wdata[7:3]))
    else $error("vector base not written");

  a_vec_brk: assert property (@(posedge clk_sys) disable iff (reset)
    !err_irq && brk_irq |-> irq_vec[2:1] == SCIR_EV_BRK)
    else $error("break source code wrong");

  a_vec_rxd: assert property (@(posedge clk_sys) disable iff (reset)
    !err_irq && !brk_irq && rxd_irq |-> irq_vec[2:1] == SCIR_EV_RXD)
    else $error("receive source code wrong");

  a_vec_txe: assert property (@(posedge clk_sys) disable iff (reset)
    !err_irq && !brk_irq && !rxd_irq |-> irq_vec[2:1] == SCIR_EV_TXE)
    else $error("transmit source code wrong");

  a_vec_read: assert property (@(posedge clk_sys) disable iff (reset)
    rsel && addr == SCIR_A_IVEC |=> rdata == $past(irq_vec))
    else $error("vector read differs from presented vector");

  // Address compare and data steering
  a_search_match: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && rx_word_valid && !idp_q[SCIR_P_AMEN] && chr_q[SCIR_C_AM] &&
    rx_word == acmp_q |=> ista_q[SCIR_S_AP])
    else $error("character search missed");

  a_match_drop: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && rx_word_valid && match |=> rxb_q == $past(rxb_q))
    else $error("address word stored");

  a_pass_store: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && rx_word_valid && pass_q && !match |=> rxb_q == $past(rx_word))
    else $error("data after address not stored");

  // Mask register
  a_mask_reset: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(reset) |-> imsk_q == SCIR_IMSK_RST)
    else $error("mask not cleared by reset");

  a_bsn_shift: assert property (@(posedge clk_sys) disable iff (reset)
    !imsk_q[SCIR_M_BSN] && imsk_q[SCIR_M_TX_DATA_IRQ_MASK] && !idp_q[SCIR_P_TXD] &&
    ista_q[SCIR_S_SEM] |-> irq_req)
    else $error("shift empty source lost");

  a_bsn_buf: assert property (@(posedge clk_sys) disable iff (reset)
    imsk_q[SCIR_M_BSN] && imsk_q[SCIR_M_TX_DATA_IRQ_MASK] && !idp_q[SCIR_P_TXD] &&
    ista_q[SCIR_S_BEM] |-> irq_req)
    else $error("buffer empty source lost");

  a_eob_rx_hold: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && !wr_at(SCIR_A_IMSK) && imsk_q[SCIR_M_RX_BLOCK_END_FLAG] |=> imsk_q[SCIR_M_RX_BLOCK_END_FLAG])
    else $error("receive block end cleared by hardware");

  a_eob_rx_clear: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_IMSK) && !wdata[SCIR_M_RX_BLOCK_END_FLAG] && !evt.rx_dma_zero
    |=> !imsk_q[SCIR_M_RX_BLOCK_END_FLAG])
    else $error("receive block end not cleared");

  a_eob_tx_hold: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && !wr_at(SCIR_A_IMSK) && imsk_q[SCIR_M_TX_BLOCK_END_FLAG] |=> imsk_q[SCIR_M_TX_BLOCK_END_FLAG])
    else $error("transmit block end cleared by hardware");

  a_eob_tx_clear: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_IMSK) && !wdata[SCIR_M_TX_BLOCK_END_FLAG] && !evt.tx_dma_zero
    |=> !imsk_q[SCIR_M_TX_BLOCK_END_FLAG])
    else $error("transmit block end not cleared");

  // Interrupt gating and DMA bypass
  a_err_on: assert property (@(posedge clk_sys) disable iff (reset)
    imsk_q[SCIR_M_RXE] && ista_q[SCIR_S_FE] |-> irq_req && irq_vec[2:1] == SCIR_EV_ERR)
    else $error("enabled error interrupt missing");

  a_addr_off: assert property (@(posedge clk_sys) disable iff (reset)
    !imsk_q[SCIR_M_RXA] && !imsk_q[SCIR_M_RXB] |-> !brk_irq)
    else $error("masked address interrupt raised");

  a_addr_on: assert property (@(posedge clk_sys) disable iff (reset)
    imsk_q[SCIR_M_RXA] && ista_q[SCIR_S_AP] |-> irq_req)
    else $error("address interrupt missing");

  a_rxd_off: assert property (@(posedge clk_sys) disable iff (reset)
    !imsk_q[SCIR_M_RX_DATA_IRQ_MASK] |-> !rxd_irq)
    else $error("masked receive interrupt raised");

  a_rx_dma_free: assert property (@(posedge clk_sys) disable iff (reset)
    idp_q[SCIR_P_RXD] && ista_q[SCIR_S_DP] |-> rx_dma_req)
    else $error("receive DMA request missing");

  a_txd_off: assert property (@(posedge clk_sys) disable iff (reset)
    !imsk_q[SCIR_M_TX_DATA_IRQ_MASK] |-> !txe_irq)
    else $error("masked transmit interrupt raised");

  a_tx_dma_free: assert property (@(posedge clk_sys) disable iff (reset)
    idp_q[SCIR_P_TXD] && !imsk_q[SCIR_M_BSN] && ista_q[SCIR_S_SEM] |-> tx_dma_req)
    else $error("transmit DMA request missing");

  a_rx_replace: assert property (@(posedge clk_sys) disable iff (reset)
    idp_q[SCIR_P_RXD] && !imsk_q[SCIR_M_RX_BLOCK_END_FLAG] |-> !rxd_irq)
    else $error("data pending interrupt during receive DMA");

  a_tx_replace: assert property (@(posedge clk_sys) disable iff (reset)
    idp_q[SCIR_P_TXD] && !imsk_q[SCIR_M_TX_BLOCK_END_FLAG] |-> !txe_irq)
    else $error("transmit empty interrupt during transmit DMA");

  a_status_clear: assert property (@(posedge clk_sys) disable iff (reset)
    wr_at(SCIR_A_ISTA) && !wdata[SCIR_S_DP] && !take_word |=> !ista_q[SCIR_S_DP])
    else $error("status flag not cleared");

  a_freeze: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> imsk_q == $past(imsk_q) && ista_q == $past(ista_q) &&
    vbase_q == $past(vbase_q))
    else $error("state moved while frozen");
endmodule

/* hw/scir_pkg.sv */
package scir_pkg;
  localparam logic [7:0] SCIR_PAGE0 = 8'h18;
  localparam logic [7:0] SCIR_PAGE1 = 8'h19;
  localparam logic [7:0] SCIR_A_RDCP = 8'hF0;
  localparam logic [7:0] SCIR_A_RDAP = 8'hF1;
  localparam logic [7:0] SCIR_A_TDCP = 8'hF2;
  localparam logic [7:0] SCIR_A_TDAP = 8'hF3;
  localparam logic [7:0] SCIR_A_IVEC = 8'hF4;
  localparam logic [7:0] SCIR_A_ACMP = 8'hF5;
  localparam logic [7:0] SCIR_A_IMSK = 8'hF6;
  localparam logic [7:0] SCIR_A_ISTA = 8'hF7;
  localparam logic [7:0] SCIR_A_BUF = 8'hF8;
  localparam logic [7:0] SCIR_A_IDP = 8'hF9;
  localparam logic [7:0] SCIR_A_CHR = 8'hFA;
  localparam logic [7:0] SCIR_A_CLK = 8'hFB;
  localparam logic [7:0] SCIR_A_BRH = 8'hFC;
  localparam logic [7:0] SCIR_A_BRL = 8'hFD;
  localparam logic [7:0] SCIR_A_SIC = 8'hFE;
  localparam logic [7:0] SCIR_A_SOC = 8'hFF;
  // Mask register fields
  localparam int SCIR_M_BSN = 7;
  localparam int SCIR_M_RX_BLOCK_END_FLAG = 6;
  localparam int SCIR_M_TX_BLOCK_END_FLAG = 5;
  localparam int SCIR_M_RXE = 4;
  localparam int SCIR_M_RXA = 3;
  localparam int SCIR_M_RXB = 2;
  localparam int SCIR_M_RX_DATA_IRQ_MASK = 1;
  localparam int SCIR_M_TX_DATA_IRQ_MASK = 0;
  localparam logic [7:0] SCIR_IMSK_RST = 8'h00;
  localparam logic [7:0] SCIR_IMSK_SWMASK = 8'h9F;
  // Status register fields
  localparam int SCIR_S_OE = 7;
  localparam int SCIR_S_FE = 6;
  localparam int SCIR_S_PE = 5;
  localparam int SCIR_S_AP = 4;
  localparam int SCIR_S_BP = 3;
  localparam int SCIR_S_DP = 2;
  localparam int SCIR_S_BEM = 1;
  localparam int SCIR_S_SEM = 0;
  // Priority register fields, and the AM bit of the CHR register
  localparam int SCIR_P_AMEN = 7;
  localparam int SCIR_P_RXD = 4;
  localparam int SCIR_P_TXD = 3;
  localparam int SCIR_C_AM = 2;
  localparam logic [7:0] SCIR_RST8 = 8'h00;

  typedef enum logic [1:0] {
    SCIR_EV_ERR = 2'b00,
    SCIR_EV_BRK = 2'b01,
    SCIR_EV_RXD = 2'b10,
    SCIR_EV_TXE = 2'b11
  } scir_ev_t;

  // Hardware events from the serial engines and DMA controller
  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
    logic brk;
    logic rx_word;
    logic tx_buf_empty;
    logic tx_shift_empty;
    logic rx_dma_zero;
    logic tx_dma_zero;
  } scir_evt_t;

  // Pointer fields offered to the DMA controller
  typedef struct packed {
    logic [6:0] rx_cnt_addr;
    logic rx_space_select;
    logic [6:0] rx_ptr_addr;
    logic rx_extension_select;
    logic [6:0] tx_cnt_addr;
    logic tx_space_select;
    logic [6:0] tx_ptr_addr;
    logic tx_extension_select;
  } scir_dma_t;
endpackage

/* tb/scir_far.sv */
`timescale 1ns/1ps
module scir_far
  import scir_pkg::*;
(
  input wire logic fire, // One-cycle event request from the bench
  input wire logic [3:0] which, // Event index, 0 is overrun
  output scir_evt_t evt, // Event pulses into the block
  output logic rx_word_valid // Received word strobe
);
  // Zero-count pulses stand in for the DMA controller reaching block end
  assign evt = fire ? scir_evt_t'(9'h100 >> which) : '0;
  assign rx_word_valid = fire && which == 4'h4;
endmodule

/* tb/scir_regs_tb.sv */
`timescale 1ns/1ps
module scir_regs_tb;
  import scir_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] page_sel = SCIR_PAGE0;
  logic [7:0] addr = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rx_word = 8'h00;
  logic rx_ninth = 1'b0;
  logic rx_after_break = 1'b0;
  logic fire = 1'b0;
  logic [3:0] which = 4'h0;
  logic [7:0] rdata, tx_data, irq_vec;
  logic rx_word_valid, rx_dma_req, tx_dma_req, tx_load, irq_req;
  scir_evt_t evt;
  scir_dma_t dma_ptr;
  int error_cnt = 0;
  int n_checks = 0;
  int n_load = 0;
  logic [31:0] seed = 32'd48767;
  logic [2:0] ebit [7] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
  logic [7:0] mon [7] = '{8'h10, 8'h10, 8'h10, 8'h04, 8'h02, 8'h81, 8'h01};
  // Off masks enable every other source, so a wrong gate shows up
  logic [7:0] moff [7] = '{8'h8F, 8'h8F, 8'h8F, 8'h9B, 8'h9D, 8'h1F, 8'h9F};
  logic [1:0] ecode [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [7:0] rwa [11] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF5, 8'hFA, 8'hFB, 8'hFC, 8'hFD,
    8'hFE, 8'hFF};

  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (tx_load === 1'b1) n_load++;

  scir_far i_far (.fire(fire), .which(which), .evt(evt), .rx_word_valid(rx_word_valid));

  scir_regs #(.PAGE(SCIR_PAGE0)) i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .page_sel(page_sel), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .evt(evt), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_ninth(rx_ninth), .rx_after_break(rx_after_break), .dma_ptr(dma_ptr),
    .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req), .tx_data(tx_data), .tx_load(tx_load), .irq_req(irq_req),
    .irq_vec(irq_vec));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] vec_exp(input logic [7:0] b, input logic [1:0] c);
    return {b[7:3], c, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
    d = rdata;
    @(negedge clk_sys);
  endtask

  task automatic pulse(input logic [3:0] w);
    which = w;
    fire = 1'b1;
    @(negedge clk_sys);
    fire = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, base, address_compare;
    logic [7:0] w [11];
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk(irq_vec, 8'h06, "vector at reset");
    rd(SCIR_A_IMSK, d);
    chk(d, SCIR_IMSK_RST, "mask at reset");
    $display("test reset done");
    foreach (rwa[i]) begin
      w[i] = rnd();
      wr(rwa[i], w[i]);
      rd(rwa[i], d);
      chk(d, w[i], "read back");
    end
    chk(dma_ptr, {w[0], w[1], w[2], w[3]}, "dma pointers");
    base = rnd() | 8'h07;
    wr(SCIR_A_IVEC, base);
    rd(SCIR_A_IVEC, d);
    chk(d, vec_exp(base, 2'h3), "vector read");
    page_sel = SCIR_PAGE1;
    wr(SCIR_A_ACMP, ~d);
    page_sel = SCIR_PAGE0;
    rd(SCIR_A_ACMP, address_compare);
    chk(address_compare, w[4], "other page ignored");
    wr(8'h10, 8'hA5);
    rd(8'h10, d);
    chk(d, 8'h00, "unmapped read");
    wr(SCIR_A_IMSK, 8'hFF);
    rd(SCIR_A_IMSK, d);
    chk(d, 8'h9F, "block end flags not settable");
    d = rnd();
    wr(SCIR_A_BUF, d);
    @(negedge clk_sys);
    chk(n_load, 1, "one load pulse");
    chk(tx_data, d, "tx data");
    $display("test registers done");
    wr(SCIR_A_IDP, 8'h00);
    wr(SCIR_A_CHR, 8'h00);
    wr(SCIR_A_ISTA, 8'h00);
    for (int k = 0; k < 7; k++) begin
      wr(SCIR_A_IMSK, moff[k]);
      rx_word = rnd();
      pulse(4'(k));
      rd(SCIR_A_ISTA, d);
      chk(d, 8'h01 << ebit[k], "status set");
      chk(irq_req, 1'b0, "gated off");
      wr(SCIR_A_IMSK, mon[k]);
      chk(irq_req, 1'b1, "gated on");
      chk(irq_vec, vec_exp(base, ecode[k]), "source code");
      if (k == 4) begin
        rd(SCIR_A_BUF, d);
        chk(d, rx_word, "rx buffer");
      end
      wr(SCIR_A_ISTA, 8'hFF);
      rd(SCIR_A_ISTA, d);
      chk(d, 8'h01 << ebit[k], "no software set");
      wr(SCIR_A_ISTA, ~(8'h01 << ebit[k]));
      chk(irq_req, 1'b0, "cleared");
    end
    $display("test sources done");
    address_compare = rnd();
    wr(SCIR_A_IDP, 8'h80);
    wr(SCIR_A_ACMP, address_compare);
    wr(SCIR_A_IMSK, 8'h08);
    rx_word = address_compare ^ 8'h01;
    pulse(4'h4);
    rd(SCIR_A_ISTA, d);
    chk(d, 8'h00, "data before address dropped");
    rx_word = address_compare;
    rx_ninth = 1'b1;
    pulse(4'h4);
    rx_ninth = 1'b0;
    rd(SCIR_A_ISTA, d);
    chk(d, 8'h10, "address match");
    chk(irq_vec, vec_exp(base, 2'h1), "address irq");
    wr(SCIR_A_ISTA, 8'hEF);
    rx_word = address_compare ^ 8'h5A;
    pulse(4'h4);
    rd(SCIR_A_ISTA, d);
    chk(d, 8'h04, "data after address");
    rd(SCIR_A_BUF, d);
    chk(d, address_compare ^ 8'h5A, "data stored");
    wr(SCIR_A_ISTA, 8'h00);
    wr(SCIR_A_IDP, 8'h00);
    wr(SCIR_A_CHR, 8'h04);
    rx_word = address_compare;
    pulse(4'h4);
    rd(SCIR_A_ISTA, d);
    chk(d, 8'h10, "character search");
    wr(SCIR_A_ISTA, 8'h00);
    wr(SCIR_A_IDP, 8'h80);
    pulse(4'h4);
    rd(SCIR_A_ISTA, d);
    chk(d[4], 1'b0, "no match without break");
    wr(SCIR_A_ISTA, 8'h00);
    rx_after_break = 1'b1;
    pulse(4'h4);
    rx_after_break = 1'b0;
    rd(SCIR_A_ISTA, d);
    chk(d, 8'h10, "match after break");
    wr(SCIR_A_ISTA, 8'h00);
    wr(SCIR_A_CHR, 8'h00);
    clk_en = 1'b0;
    wr(SCIR_A_IVEC, ~base);
    clk_en = 1'b1;
    rd(SCIR_A_IVEC, d);
    chk(d, vec_exp(base, 2'h3), "frozen write ignored");
    $display("test address done");
    wr(SCIR_A_IDP, 8'h18);
    pulse(4'h7);
    rd(SCIR_A_IDP, d);
    chk(d, 8'h08, "rx dma stop");
    pulse(4'h8);
    rd(SCIR_A_IDP, d);
    chk(d, 8'h00, "tx dma stop");
    rd(SCIR_A_IMSK, d);
    chk(d, 8'h68, "block end flags");
    wr(SCIR_A_IMSK, 8'h28);
    rd(SCIR_A_IMSK, d);
    chk(d, 8'h28, "rx block end cleared");
    wr(SCIR_A_IMSK, 8'h08);
    rd(SCIR_A_IMSK, d);
    chk(d, 8'h08, "tx block end cleared");
    $display("test dma done");
    print_verdict();
  end
endmodule
